//--- src/mcs_pkg.sv
// package for the multiply and compare-skip execution block
package mcs_pkg;

  // instruction kinds handed over by the decoder
  typedef enum logic [2:0] {
    MCS_OP_NONE = 3'h0,
    MCS_OP_MUL_IMMEDIATE = 3'h1,
    MCS_OP_MUL_REGISTER = 3'h2,
    MCS_OP_CMP_SKIP_GREATER = 3'h3,
    MCS_OP_CMP_SKIP_LESS = 3'h4
  } mcs_op_type;

  // one-hot phase codes of an instruction cycle
  typedef enum logic [3:0] {
    MCS_PH_Q1 = 4'h1,
    MCS_PH_Q2 = 4'h2,
    MCS_PH_Q3 = 4'h4,
    MCS_PH_Q4 = 4'h8
  } mcs_phase_type;

  localparam logic [7:0] MCS_BYTE_ZERO = 8'h00;
  localparam logic [15:0] MCS_PROD_ZERO = 16'h0000;
  localparam logic [1:0] MCS_SKIP_ZERO = 2'h0;
  localparam logic [1:0] MCS_SKIP_ONE_WORD = 2'h1;
  localparam logic [1:0] MCS_SKIP_TWO_WORD = 2'h2;
  localparam logic [3:0] MCS_ACCESS_BANK = 4'h0;
  localparam logic [11:0] MCS_ADDR_ZERO = 12'h000;
  // bit of the one-hot phase code that marks the first phase
  localparam int MCS_PH_Q1_BIT = 0;

  // instruction presented at the start of a cycle
  typedef struct packed {
    mcs_op_type op;
    logic [7:0] literal;
    logic [7:0] fileAddr;
    logic accessSel;
  } mcs_instr_type;

  // data-memory read port
  typedef struct packed {
    logic [11:0] addr;
    logic rdEn;
  } mcs_mem_req_type;

  // complete state of the block
  typedef struct packed {
    mcs_phase_type phase;
    mcs_op_type op;
    logic [7:0] operand;
    logic [15:0] product;
    logic [7:0] productHigh;
    logic [7:0] productLow;
    logic prodWrite;
    logic skipTaken;
    logic [1:0] skipLeft;
    logic nopCycle;
    logic instrReady;
    mcs_mem_req_type memReq;
  } mcs_state_type;

endpackage

//--- src/mcs_exec.sv
// execution of unsigned multiplies and compare-and-skip cycle timing
`timescale 1ns/1ps
module mcs_exec (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // decoder side
  input wire mcs_pkg::mcs_instr_type instr,
  input wire logic nextIsTwoWord,
  output logic instrReady_r,
  output logic phaseQ1_r,
  // working register and bank select
  input wire logic [7:0] workingReg,
  input wire logic [3:0] bankSelectReg,
  // data memory read
  output mcs_pkg::mcs_mem_req_type memReq_r,
  input wire logic [7:0] memRdata,
  // product registers and skip report
  output logic [7:0] productHigh_r,
  output logic [7:0] productLow_r,
  output logic prodWrite_r,
  output logic skipTaken_r,
  output logic nopCycle_r
);
  import mcs_pkg::*;

  // the whole block state is one struct: the flops and their next value
  mcs_state_type state_r;
  mcs_state_type state_nxt;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // borrow out of the unsigned subtraction a - b, set exactly when a < b;
  // a ninth bit is carried so that no signed compare can creep in
  function automatic logic mcsBorrow(input logic [7:0] a, input logic [7:0] b);
    logic borrow;
    logic [7:0] diff;
    {borrow, diff} = {1'b0, a} - {1'b0, b};
    return borrow;
  endfunction

  // full 16-bit unsigned product of two bytes; both factors are widened first
  // so that the high byte is never lost to an 8-bit context
  function automatic logic [15:0] mcsProduct(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] wideA;
    logic [15:0] wideB;
    wideA = {MCS_BYTE_ZERO, a};
    wideB = {MCS_BYTE_ZERO, b};
    return wideA * wideB;
  endfunction

  // instruction kinds that fetch their operand from data memory in phase two
  function automatic logic mcsReadsFile(input mcs_op_type op);
    return (op == MCS_OP_MUL_REGISTER) || (op == MCS_OP_CMP_SKIP_GREATER) || (op == MCS_OP_CMP_SKIP_LESS);
  endfunction

  // instruction kinds that write the product register pair in phase four
  function automatic logic mcsIsMultiply(input mcs_op_type op);
    return (op == MCS_OP_MUL_IMMEDIATE) || (op == MCS_OP_MUL_REGISTER);
  endfunction

  // data-memory address of a file operand: the access bank when access-select
  // is clear, otherwise the bank held in the bank select register
  function automatic logic [11:0] mcsFileAddr(input logic accessSel, input logic [3:0] bank,
    input logic [7:0] offset);
    logic [11:0] addr;
    if (accessSel) begin
      addr = {bank, offset};
    end else begin
      addr = {MCS_ACCESS_BANK, offset};
    end
    return addr;
  endfunction

  // skip condition of a compare: greater skips when f > W, so W - f borrows;
  // less skips when f < W, so f - W borrows; equal operands never skip
  function automatic logic mcsSkipHolds(input mcs_op_type op, input logic [7:0] fileVal,
    input logic [7:0] work);
    logic holds;
    holds = 1'b0;
    if (op == MCS_OP_CMP_SKIP_GREATER) begin
      holds = mcsBorrow(work, fileVal);
    end else if (op == MCS_OP_CMP_SKIP_LESS) begin
      holds = mcsBorrow(fileVal, work);
    end
    return holds;
  endfunction

  // whole cycles to discard after a taken skip: one per word of the skipped
  // instruction, so a two-word instruction costs a third cycle
  function automatic logic [1:0] mcsSkipWords(input logic twoWord);
    logic [1:0] words;
    if (twoWord) begin
      words = MCS_SKIP_TWO_WORD;
    end else begin
      words = MCS_SKIP_ONE_WORD;
    end
    return words;
  endfunction

  // state after reset: first phase, nothing pending, ready for an instruction
  function automatic mcs_state_type mcsResetState();
    mcs_state_type s;
    s.phase = MCS_PH_Q1;
    s.op = MCS_OP_NONE;
    s.operand = MCS_BYTE_ZERO;
    s.product = MCS_PROD_ZERO;
    s.productHigh = MCS_BYTE_ZERO;
    s.productLow = MCS_BYTE_ZERO;
    s.prodWrite = 1'b0;
    s.skipTaken = 1'b0;
    s.skipLeft = MCS_SKIP_ZERO;
    s.nopCycle = 1'b0;
    s.instrReady = 1'b1;
    s.memReq.addr = MCS_ADDR_ZERO;
    s.memReq.rdEn = 1'b0;
    return s;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------

  // one pass of the four-phase ring per instruction cycle; pulses default low
  always_comb begin
    state_nxt = state_r;
    state_nxt.prodWrite = 1'b0;
    state_nxt.memReq.rdEn = 1'b0;
    case (state_r.phase)
      // phase one: decode, or turn the whole cycle into a discard
      MCS_PH_Q1: begin
        state_nxt.phase = MCS_PH_Q2;
        state_nxt.instrReady = 1'b0;
        state_nxt.skipTaken = 1'b0;
        if (state_r.skipLeft != MCS_SKIP_ZERO) begin
          // a pending discard swallows the presented word; nothing reads or writes
          state_nxt.op = MCS_OP_NONE;
          state_nxt.nopCycle = 1'b1;
          state_nxt.skipLeft = state_r.skipLeft - MCS_SKIP_ONE_WORD;
        end else begin
          state_nxt.op = instr.op;
          state_nxt.nopCycle = 1'b0;
          // the literal rides along with the decoded word
          state_nxt.operand = instr.literal;
          // file operands launch their address now so the data stands in phase two
          if (mcsReadsFile(instr.op)) begin
            state_nxt.memReq.rdEn = 1'b1;
            state_nxt.memReq.addr = mcsFileAddr(instr.accessSel, bankSelectReg, instr.fileAddr);
          end
        end
      end
      // phase two: read the file operand; the literal is already held
      MCS_PH_Q2: begin
        state_nxt.phase = MCS_PH_Q3;
        if (mcsReadsFile(state_r.op)) begin
          state_nxt.operand = memRdata;
        end
      end
      // phase three: process; the working register is only read, never written
      MCS_PH_Q3: begin
        state_nxt.phase = MCS_PH_Q4;
        state_nxt.product = mcsProduct(workingReg, state_r.operand);
        if (mcsSkipHolds(state_r.op, state_r.operand, workingReg)) begin
          state_nxt.skipTaken = 1'b1;
        end
      end
      // phase four: write the product pair; a taken skip arms the discard count
      MCS_PH_Q4: begin
        state_nxt.phase = MCS_PH_Q1;
        // the next word is accepted only when no discard is pending or about to start
        state_nxt.instrReady = (state_r.skipLeft == MCS_SKIP_ZERO) && !state_r.skipTaken;
        if (mcsIsMultiply(state_r.op)) begin
          {state_nxt.productHigh, state_nxt.productLow} = state_r.product;
          state_nxt.prodWrite = 1'b1;
        end
        if (state_r.skipTaken) begin
          state_nxt.skipLeft = mcsSkipWords(nextIsTwoWord);
        end
      end
      // an illegal phase code falls back into the ring at phase one
      default: begin
        state_nxt.phase = MCS_PH_Q1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------

  // synchronous reset parks the ring at phase one with the decoder free to issue
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= mcsResetState();
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------

  // every output is a bare state flop, so no decode glitch reaches the core
  assign instrReady_r = state_r.instrReady;
  assign phaseQ1_r = state_r.phase[MCS_PH_Q1_BIT];
  assign memReq_r = state_r.memReq;
  assign productHigh_r = state_r.productHigh;
  assign productLow_r = state_r.productLow;
  assign prodWrite_r = state_r.prodWrite;
  assign skipTaken_r = state_r.skipTaken;
  assign nopCycle_r = state_r.nopCycle;

endmodule

//--- test/mcs_mem_model.sv
// data-memory model on the block's read port
`timescale 1ns/1ps
module mcs_mem_model (
  // clock and read port
  input wire logic clk,
  input wire mcs_pkg::mcs_mem_req_type memReq,
  output logic [7:0] memRdata
);
  logic [7:0] junk = 8'h5a;
  // idle data moves each cycle so a stray sample never looks valid
  always @(posedge clk) junk <= ~junk + 8'h01;
  // combinational read of a fixed mix of bank and offset
  assign memRdata = memReq.rdEn ? memReq.addr[7:0] ^ {2{memReq.addr[11:8]}} : junk;
endmodule

//--- test/mcs_exec_props.sv
// assertions for the multiply and compare-skip block
`timescale 1ns/1ps
module mcs_exec_props import mcs_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // decoder side
  input wire mcs_instr_type instr,
  input wire logic nextIsTwoWord,
  input wire logic instrReady_r,
  input wire logic phaseQ1_r,
  // working register and bank select
  input wire logic [7:0] workingReg,
  input wire logic [3:0] bankSelectReg,
  // data memory read
  input wire mcs_mem_req_type memReq_r,
  input wire logic [7:0] memRdata,
  // product registers and skip report
  input wire logic [7:0] productHigh_r,
  input wire logic [7:0] productLow_r,
  input wire logic prodWrite_r,
  input wire logic skipTaken_r,
  input wire logic nopCycle_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // an instruction is taken at a ready phase-one edge
  wire take = phaseQ1_r && instrReady_r;
  wire [15:0] prod = {productHigh_r, productLow_r};
  // the skip flag stands over phase four and the next phase one; count from phase four only
  wire skipSeen = skipTaken_r && !phaseQ1_r;
  chk_phase_ring: assert property (phaseQ1_r |=> !phaseQ1_r [*3] ##1 phaseQ1_r) else $error("phase");
  chk_mul_imm: assert property (take && instr.op == MCS_OP_MUL_IMMEDIATE |-> ##4 prodWrite_r &&
    prod == 16'($past(instr.literal, 4)) * 16'($past(workingReg, 2))) else $error("imm product");
  chk_mul_file: assert property (take && instr.op == MCS_OP_MUL_REGISTER |-> ##1 memReq_r.rdEn &&
    memReq_r.addr == {$past(instr.accessSel) ? $past(bankSelectReg) : MCS_ACCESS_BANK, $past(instr.fileAddr)}
    ##3 prodWrite_r && prod == 16'($past(memRdata, 3)) * 16'($past(workingReg, 2))) else $error("file product");
  chk_skip_greater: assert property (take && instr.op == MCS_OP_CMP_SKIP_GREATER |->
    ##3 skipTaken_r == ($past(memRdata, 2) > $past(workingReg))) else $error("greater");
  chk_skip_less: assert property (take && instr.op == MCS_OP_CMP_SKIP_LESS |->
    ##3 skipTaken_r == ($past(memRdata, 2) < $past(workingReg))) else $error("less");
  chk_discard_nop: assert property (skipSeen |-> ##2 (nopCycle_r && !memReq_r.rdEn && !prodWrite_r) [*4])
    else $error("discard busy");
  chk_discard_ready: assert property (skipTaken_r |=> !instrReady_r) else $error("discard ready");
  chk_two_word: assert property (skipSeen && nextIsTwoWord |-> ##5 phaseQ1_r && !instrReady_r)
    else $error("two word");
  chk_one_word: assert property (skipSeen && !nextIsTwoWord |-> ##5 instrReady_r) else $error("one word");
  chk_prod_pulse: assert property (prodWrite_r |-> phaseQ1_r ##1 !prodWrite_r) else $error("pulse");
  cover property (prodWrite_r);
  cover property (skipTaken_r && nextIsTwoWord);
  cover property (skipTaken_r && !nextIsTwoWord);
endmodule
bind mcs_exec mcs_exec_props u_props (.clk, .reset, .nextIsTwoWord, .instrReady_r, .phaseQ1_r, .prodWrite_r,
  .skipTaken_r, .nopCycle_r, .instr, .memReq_r, .workingReg, .memRdata, .productHigh_r, .productLow_r, .bankSelectReg);

//--- test/mcs_exec_bench.sv
// self-checking bench for the multiply and compare-skip block
`timescale 1ns/1ps
module mcs_exec_bench;
  import mcs_pkg::*;
  logic clk = 0, reset = 1, nextIsTwoWord = 0, instrReady_r, phaseQ1_r, prodWrite_r, skipTaken_r, nopCycle_r;
  mcs_instr_type instr = '0;
  logic [7:0] workingReg = 8'h00, memRdata, productHigh_r, productLow_r;
  logic [3:0] bankSelectReg = 4'h0;
  mcs_mem_req_type memReq_r;
  logic [15:0] prodQ[$];
  int gapQ[$], gap = 0, fail_count = 0, check_count = 0, seed = 32'h8bad;
  always #5 clk = ~clk;
  mcs_exec u_dut (.clk, .reset, .instr, .nextIsTwoWord, .instrReady_r, .phaseQ1_r, .workingReg, .bankSelectReg,
    .memReq_r, .memRdata, .productHigh_r, .productLow_r, .prodWrite_r, .skipTaken_r, .nopCycle_r);
  mcs_mem_model u_mem (.clk, .memReq(memReq_r), .memRdata);
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // wait for a ready phase one, present one instruction and note its results
  task issue(mcs_op_type op, logic two);
    logic [7:0] f;
    logic [7:0] w;
    do @(posedge clk) #1; while (!(phaseQ1_r === 1'b1 && instrReady_r === 1'b1));
    instr = '{op, 8'($random(seed)), 8'($random(seed)), 1'($random(seed))};
    w = 8'($random(seed));
    bankSelectReg = 4'($random(seed));
    nextIsTwoWord = two;
    f = instr.fileAddr ^ {2{instr.accessSel ? bankSelectReg : 4'h0}};
    if (w[7:5] == 3'h0) w = f; // equal operands must not skip
    workingReg = w;
    if (op == MCS_OP_MUL_IMMEDIATE) prodQ.push_back(16'(workingReg) * instr.literal);
    if (op == MCS_OP_MUL_REGISTER) prodQ.push_back(16'(workingReg) * f);
    if (op != MCS_OP_NONE) gapQ.push_back((op == MCS_OP_CMP_SKIP_GREATER && f > workingReg) ||
      (op == MCS_OP_CMP_SKIP_LESS && f < workingReg) ? (two ? 12 : 8) : 4);
  endtask
  // watcher: products on each write pulse, cycle count between taken instructions
  always @(posedge clk) begin
    if (prodWrite_r === 1'b1) check("product", {productHigh_r, productLow_r}, prodQ.pop_front());
    if (phaseQ1_r === 1'b1 && instrReady_r === 1'b1 && !reset) begin
      if (gap != 0) check("cycles", 16'(gap), 16'(gapQ.pop_front()));
      gap = int'(instr.op != MCS_OP_NONE);
    end else if (gap != 0) gap++;
  end
  task results;
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 reset = 0;
    for (int i = 0; i < 200; i++) issue(mcs_op_type'(1 + i % 4), i[3]);
    issue(MCS_OP_NONE, 1'b0);
    repeat (12) @(posedge clk);
    check("pending", 16'(prodQ.size() + gapQ.size()), 16'h0000);
    results();
  end
  // watchdog well past the longest expected run
  initial begin
    #100000;
    fail_count++;
    results();
  end
endmodule
